// ===== diag_test_config_regs.sv
/*
 * Diagnostic configuration register bank: test-current steering, mux test
 * routing, alternate switch path, diagnostic select, converter forcing and
 * ALU test-word injection, plus the diagnostic result word.
 * Assumes a plain register port synchronous to clk, read data one cycle
 * after the read strobe, and converter strobes synchronous to clk.
 */
// Strobed register access was left to the implementer.
// Behaviour
// - Level code scales common test current linearly
// - Top code gives 100 or 50 uA
// - Direction one sources from supply, zero sinks
// - Lowest cell input always sources from supply
// - Aux enables share level and direction
// - Bus select picks even or odd output
// - Pairing zero drives both outputs, else one
// - Mux source enable latched at cycle start
// - Alternate path measures switch inputs instead
// - Three-bit select chooses diagnostic measurement
// - Zero-scale forces 000, full-scale forces fff
// - Reserved diagnostic configuration bits read zero
// - Thirteen per-cell source enables share settings
// - Word A injected on odd sample first conversion
// - Result register holds left-justified fourteen bits
// - Word B injected on odd sample second conversion
`timescale 1ns/1ns
`include "diag_cfg_consts.svh"

module diag_test_config_regs
    import diag_cfg_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire reg_req_t    req,
    output logic [15:0]      rdata,
    input  wire logic        current_scale_half,
    input  wire logic        alu_diag_enable,
    input  wire logic        meas_cycle_start,
    input  wire logic        diag_meas_valid,
    input  wire logic [13:0] diag_meas_data,
    input  wire conv_in_t    conv_in,
    output conv_out_t        conv_out,
    output logic [16:0]      test_current_na,
    output logic [12:0]      cell_source_on,
    output logic [12:0]      cell_source_from_supply,
    output logic [1:0]       aux_source_on,
    output logic [1:0]       aux_source_from_supply,
    output logic             hv_mux_drive_even,
    output logic             hv_mux_drive_odd,
    output logic             alternate_path_select,
    output diag_sel_t        diagnostic_select
);

    // ----------------------------------------
    // Storage
    // ----------------------------------------
    logic [15:0] diag_config;
    logic [15:0] cell_test_current_enable;
    logic [15:0] alu_test_word_odd_first;
    logic [15:0] alu_test_word_odd_second;
    logic [15:0] diag_result;
    logic        mux_enable_latched;

    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    wire logic wr_cfg  = req.wr && hit(req.addr, `ADDR_DIAG_CONFIG);
    wire logic wr_cell = req.wr && hit(req.addr, `ADDR_CELL_TEST_EN);
    wire logic wr_wa   = req.wr && hit(req.addr, `ADDR_ALU_WORD_A);
    wire logic wr_wb   = req.wr && hit(req.addr, `ADDR_ALU_WORD_B);

    logic [15:0] next_rdata;
    always_comb
    begin
        next_rdata = 16'h0000;
        if (req.rd)
        begin
            case (req.addr)
                `ADDR_DIAG_RESULT:  next_rdata = diag_result;
                `ADDR_DIAG_CONFIG:  next_rdata = diag_config & `MASK_DIAG_CONFIG;
                `ADDR_CELL_TEST_EN: next_rdata = cell_test_current_enable;
                `ADDR_ALU_WORD_A:   next_rdata = alu_test_word_odd_first;
                `ADDR_ALU_WORD_B:   next_rdata = alu_test_word_odd_second;
                default:            next_rdata = 16'h0000;
            endcase
        end
    end

    // ----------------------------------------
    // Register writes
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            diag_config <= `RST_REG16;
        else if (wr_cfg)
            diag_config <= req.wdata & `MASK_DIAG_CONFIG;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            cell_test_current_enable <= `RST_REG16;
        else if (wr_cell)
            cell_test_current_enable <= req.wdata & `MASK_CELL_TEST_EN;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            alu_test_word_odd_first <= `RST_REG16;
        else if (wr_wa)
            alu_test_word_odd_first <= req.wdata & `MASK_ALU_WORD;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            alu_test_word_odd_second <= `RST_REG16;
        else if (wr_wb)
            alu_test_word_odd_second <= req.wdata & `MASK_ALU_WORD;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            rdata <= `RST_REG16;
        else
            rdata <= next_rdata;
    end

    // ----------------------------------------
    // Diagnostic result capture
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            diag_result <= `RST_REG16;
        else if (diag_meas_valid)
            diag_result <= {diag_meas_data, 2'b00};
    end

    // ----------------------------------------
    // Test current sources
    // ----------------------------------------
    wire logic [3:0]  level_code = diag_config[`F_LEVEL_HI:`F_LEVEL_LO];
    wire logic        direction  = diag_config[`F_DIRECTION];
    wire logic [16:0] step_na    = current_scale_half ? `STEP_HALF_NA : `STEP_FULL_NA;
    wire logic [16:0] steps      = {12'h000, {1'b0, level_code} + 5'h01};
    wire logic [33:0] product    = steps * step_na;

    // Code n gives (n+1) steps, so the top code lands on 100 or 50 uA
    wire logic [16:0] next_test_current_na = product[16:0];

    wire logic [12:0] next_cell_source_on;
    wire logic [12:0] next_cell_source_from_supply;
    wire logic [1:0]  next_aux_source_on;
    wire logic [1:0]  next_aux_source_from_supply;

    genvar g;
    generate
        for (g = 0; g < 13; g = g + 1)
        begin : g_cell_src
            assign next_cell_source_on[g] = cell_test_current_enable[g];
            if (g == 0)
            begin : g_lowest
                // Lowest input sources from supply whatever the direction
                assign next_cell_source_from_supply[g] = 1'b1;
            end
            else
            begin : g_upper
                assign next_cell_source_from_supply[g] = direction;
            end
        end
        for (g = 0; g < 2; g = g + 1)
        begin : g_aux_src
            assign next_aux_source_on[g]          = diag_config[`F_AUX_LO + g];
            assign next_aux_source_from_supply[g] = direction;
        end
    endgenerate

    // ----------------------------------------
    // Registered source outputs
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            test_current_na <= `RST_CURRENT_NA;
        else
            test_current_na <= next_test_current_na;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            cell_source_on <= `RST_CELL_ON;
        else
            cell_source_on <= next_cell_source_on;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            cell_source_from_supply <= `RST_CELL_DIR;
        else
            cell_source_from_supply <= next_cell_source_from_supply;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            aux_source_on <= `RST_AUX;
        else
            aux_source_on <= next_aux_source_on;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            aux_source_from_supply <= `RST_AUX;
        else
            aux_source_from_supply <= next_aux_source_from_supply;
    end

    // ----------------------------------------
    // Mux test-current routing
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            mux_enable_latched <= `RST_BIT;
        else if (meas_cycle_start)
            mux_enable_latched <= diag_config[`F_MUX_ENABLE];
    end

    wire logic mux_single = diag_config[`F_MUX_SINGLE];
    wire logic mux_odd    = diag_config[`F_MUX_OUTPUT];

    wire logic      next_hv_mux_drive_even     = mux_enable_latched && (!mux_single || !mux_odd);
    wire logic      next_hv_mux_drive_odd      = mux_enable_latched && (!mux_single || mux_odd);
    wire logic      next_alternate_path_select = diag_config[`F_ALT_PATH];
    wire diag_sel_t next_diagnostic_select     = diag_sel_t'(diag_config[`F_DIAG_HI:`F_DIAG_LO]);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            hv_mux_drive_even <= `RST_BIT;
        else
            hv_mux_drive_even <= next_hv_mux_drive_even;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            hv_mux_drive_odd <= `RST_BIT;
        else
            hv_mux_drive_odd <= next_hv_mux_drive_odd;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            alternate_path_select <= `RST_BIT;
        else
            alternate_path_select <= next_alternate_path_select;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            diagnostic_select <= diag_sel_t'(`RST_DIAG_SEL);
        else
            diagnostic_select <= next_diagnostic_select;
    end

    // ----------------------------------------
    // Converter data path
    // ----------------------------------------
    wire logic inject_a = alu_diag_enable && conv_in.odd_sample && conv_in.first_conv;
    wire logic inject_b = alu_diag_enable && conv_in.odd_sample && conv_in.second_conv;

    logic [11:0] next_conv_data;
    always_comb
    begin
        next_conv_data = conv_in.data;
        case (diagnostic_select)
            DIAG_ZERO_SCALE: next_conv_data = `CONV_ZERO_SCALE;
            DIAG_FULL_SCALE: next_conv_data = `CONV_FULL_SCALE;
            default:         next_conv_data = conv_in.data;
        endcase
        if (inject_a)
            next_conv_data = alu_test_word_odd_first[11:0];
        else if (inject_b)
            next_conv_data = alu_test_word_odd_second[11:0];
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            conv_out <= '0;
        else
        begin
            conv_out.valid <= conv_in.valid;
            conv_out.data  <= next_conv_data;
        end
    end

endmodule

// ===== diag_cfg_consts.svh
/*
 * Offsets, field positions, masks, reset values and current steps of the
 * diagnostic configuration register bank.
 * Assumes an 8-bit register address and 16-bit register words.
 */
`ifndef DIAG_CFG_CONSTS_SVH
`define DIAG_CFG_CONSTS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ADDR_DIAG_RESULT       8'h50
`define ADDR_DIAG_CONFIG       8'h51
`define ADDR_CELL_TEST_EN      8'h52
`define ADDR_ALU_WORD_A        8'h57
`define ADDR_ALU_WORD_B        8'h58

// ----------------------------------------
// Writable bit masks
// ----------------------------------------
`define MASK_DIAG_CONFIG       16'hfbdf
`define MASK_CELL_TEST_EN      16'h1fff
`define MASK_ALU_WORD          16'h0fff

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_REG16              16'h0000
`define RST_BIT                1'b0
`define RST_CURRENT_NA         17'h0186a
`define RST_CELL_ON            13'h0000
`define RST_CELL_DIR           13'h0001
`define RST_AUX                2'h0
`define RST_DIAG_SEL           3'h0

// ----------------------------------------
// Field positions in diag_config
// ----------------------------------------
`define F_LEVEL_HI             15
`define F_LEVEL_LO             12
`define F_DIRECTION            11
`define F_AUX_HI               9
`define F_AUX_LO               8
`define F_MUX_OUTPUT           7
`define F_MUX_SINGLE           6
`define F_MUX_ENABLE           4
`define F_ALT_PATH             3
`define F_DIAG_HI              2
`define F_DIAG_LO              0

// ----------------------------------------
// Test current per code step, in nA
// ----------------------------------------
`define STEP_FULL_NA           17'h0186a
`define STEP_HALF_NA           17'h00c35

// ----------------------------------------
// Forced converter words
// ----------------------------------------
`define CONV_ZERO_SCALE        12'h000
`define CONV_FULL_SCALE        12'hfff

`endif

// ===== diag_cfg_pkg.sv
/*
 * Types of the diagnostic configuration register bank.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package diag_cfg_pkg;

    typedef enum logic [2:0]
    {
        DIAG_NONE       = 3'b000,
        DIAG_ALT_REF    = 3'b001,
        DIAG_SUPPLY     = 3'b010,
        DIAG_AMP_OFFSET = 3'b011,
        DIAG_ZERO_SCALE = 3'b100,
        DIAG_FULL_SCALE = 3'b101,
        DIAG_DIE_TEMP   = 3'b110,
        DIAG_NONE_ALT   = 3'b111
    } diag_sel_t;

    typedef struct packed
    {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [15:0] wdata;
    } reg_req_t;

    typedef struct packed
    {
        logic        valid;
        logic        first_conv;
        logic        second_conv;
        logic        odd_sample;
        logic [11:0] data;
    } conv_in_t;

    typedef struct packed
    {
        logic        valid;
        logic [11:0] data;
    } conv_out_t;

endpackage

// ===== diag_cfg_checker.sv
/* Assertions on the ports of the diagnostic configuration bank.
   Assumes it is bound into diag_test_config_regs. */
`timescale 1ns/1ns
module diag_cfg_checker
    import diag_cfg_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst_n,
    input wire reg_req_t    req,
    input wire logic [15:0] rdata,
    input wire logic        alu_diag_enable,
    input wire logic        meas_cycle_start,
    input wire conv_in_t    conv_in,
    input wire conv_out_t   conv_out,
    input wire logic [16:0] test_current_na,
    input wire logic [12:0] cell_source_from_supply,
    input wire logic [1:0]  aux_source_from_supply,
    input wire logic        hv_mux_drive_even,
    input wire logic        hv_mux_drive_odd,
    input wire diag_sel_t   diagnostic_select
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    low_cell_a: assert property (cell_source_from_supply[0])
        else $error("lowest cell not sourced");
    cell_dir_a: assert property (cell_source_from_supply[12:1] == {12{cell_source_from_supply[1]}})
        else $error("cell directions differ");
    aux_dir_a: assert property (aux_source_from_supply == {2{cell_source_from_supply[1]}})
        else $error("aux direction differs");
    mux_latch_a: assert property (!$past(meas_cycle_start, 2) |-> $stable(hv_mux_drive_even | hv_mux_drive_odd))
        else $error("mux enable moved off cycle start");
    zero_force_a: assert property (conv_in.valid && !alu_diag_enable && diagnostic_select == DIAG_ZERO_SCALE
        |=> conv_out.data == 12'h000)
        else $error("zero scale not forced");
    full_force_a: assert property (conv_in.valid && !alu_diag_enable && diagnostic_select == DIAG_FULL_SCALE
        |=> conv_out.data == 12'hfff)
        else $error("full scale not forced");
    level_step_a: assert property (test_current_na % 17'h00c35 == 0 && test_current_na inside {[17'h00c35:17'h186a0]})
        else $error("current off step");
    cfg_resv_a: assert property ($past(req.rd) && $past(req.addr) == 8'h51 |-> rdata[10] == 1'b0 && !rdata[5])
        else $error("config reserved bit set");
    result_low_a: assert property ($past(req.rd) && $past(req.addr) == 8'h50 |-> rdata[1:0] == 2'b00)
        else $error("result low bits set");
endmodule

bind diag_test_config_regs diag_cfg_checker chk (.clk, .rst_n, .req, .rdata, .alu_diag_enable, .meas_cycle_start,
    .conv_in, .conv_out, .test_current_na, .cell_source_from_supply, .aux_source_from_supply,
    .hv_mux_drive_even, .hv_mux_drive_odd, .diagnostic_select);

// ===== tb_top.sv
/* Self-checking bench of the diagnostic configuration bank.
   Assumes the register port and converter timing of the hand-over. */
`timescale 1ns/1ns
module tb_top
    import diag_cfg_pkg::*;
;
    logic        clk, rst_n, current_scale_half, alu_diag_enable, meas_cycle_start, diag_meas_valid, ml;
    logic [13:0] diag_meas_data;
    reg_req_t    req;
    conv_in_t    conv_in;
    conv_out_t   conv_out;
    logic [15:0] rdata, d;
    logic [16:0] test_current_na;
    logic [12:0] cell_source_on, cell_source_from_supply;
    logic [1:0]  aux_source_on, aux_source_from_supply;
    logic        hv_mux_drive_even, hv_mux_drive_odd, alternate_path_select;
    diag_sel_t   diagnostic_select;
    logic [15:0] mr [0:255];
    logic [7:0]  adr [6] = '{8'h50, 8'h51, 8'h52, 8'h57, 8'h58, 8'h53};
    integer      failures = 0, n_compared = 0, seed = 32'h8397, cyc = 0, i;

    diag_test_config_regs uut (.clk, .rst_n, .req, .rdata, .current_scale_half, .alu_diag_enable,
        .meas_cycle_start, .diag_meas_valid, .diag_meas_data, .conv_in, .conv_out, .test_current_na,
        .cell_source_on, .cell_source_from_supply, .aux_source_on, .aux_source_from_supply,
        .hv_mux_drive_even, .hv_mux_drive_odd, .alternate_path_select, .diagnostic_select);

    always #25 clk = ~clk;
    always @(posedge clk)
    begin
        cyc = cyc + 1;
        if (cyc == 5000)
        begin
            failures = failures + 1;
            tally_and_finish();
        end
    end
    // ----
    // Checking and bus tasks
    // ----
    task tally_and_finish();
        $display("compared %0d mismatched %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task chk(input string n, input logic [16:0] s, input logic [16:0] e);
        n_compared = n_compared + 1;
        if (s !== e)
        begin
            failures = failures + 1;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask
    function automatic logic [15:0] msk(input logic [7:0] ad);
        case (ad)
            8'h51:        msk = 16'hfbdf;
            8'h52:        msk = 16'h1fff;
            8'h57, 8'h58: msk = 16'h0fff;
            default:      msk = 16'h0000;
        endcase
    endfunction
    task wr(input logic [7:0] ad, input logic [15:0] wd);
        @(posedge clk);
        req <= '{1'b1, 1'b0, ad, wd};
        mr[ad] = wd & msk(ad);
        @(posedge clk);
        req <= '0;
        #1;
    endtask
    task rd(input logic [7:0] ad);
        @(posedge clk);
        req <= '{1'b0, 1'b1, ad, 16'h0000};
        @(posedge clk);
        req <= '0;
        #1;
        chk("rdata", {1'b0, rdata}, {1'b0, mr[ad]});
    endtask
    task outs();
        logic [15:0] c;
        @(posedge clk);
        #1;
        c = mr[8'h51];
        chk("current", test_current_na, (c[15:12] + 17'h00001) * (current_scale_half ? 17'h00c35 : 17'h0186a));
        chk("cell_on", {4'h0, cell_source_on}, {4'h0, mr[8'h52][12:0]});
        chk("cell_dir", {4'h0, cell_source_from_supply}, {4'h0, {12{c[11]}}, 1'b1});
        chk("aux", {13'h0, aux_source_on, aux_source_from_supply}, {13'h0, c[9:8], {2{c[11]}}});
        chk("alt", {16'h0, alternate_path_select}, {16'h0, c[3]});
        chk("dsel", {14'h0, diagnostic_select}, {14'h0, c[2:0]});
        chk("mux", {15'h0, hv_mux_drive_even, hv_mux_drive_odd}, {15'h0, {2{ml}} & {~c[6] | ~c[7], ~c[6] | c[7]}});
    endtask
    task conv(input logic [2:0] q, input logic [11:0] e);
        @(posedge clk);
        conv_in <= '{1'b1, q[2], q[1], q[0], d[11:0]};
        @(posedge clk);
        conv_in <= '0;
        #1;
        chk("conv", {4'h0, conv_out.valid, conv_out.data}, {4'h0, 1'b1, e});
    endtask
    // ----
    // Main sequence
    // ----
    initial
    begin
        {clk, rst_n, current_scale_half, alu_diag_enable, meas_cycle_start, diag_meas_valid, ml} = 7'h00;
        {diag_meas_data, req, conv_in, d} = '0;
        for (i = 0; i < 256; i++)
            mr[i] = 16'h0000;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        for (i = 0; i < 6; i++)
            rd(adr[i]);
        outs();
        for (i = 0; i < 64; i++)
        begin
            d = $random(seed);
            @(posedge clk);
            current_scale_half <= d[15];
            wr(8'h51, {i[3:0], d[11:0]});
            if (d[13])
            begin
                @(posedge clk);
                meas_cycle_start <= 1'b1;
                @(posedge clk);
                meas_cycle_start <= 1'b0;
                ml = mr[8'h51][4];
                #1;
            end
            outs();
            d = $random(seed);
            wr(adr[i % 6], d);
            rd(adr[i % 6]);
            outs();
        end
        for (i = 0; i < 8; i++)
        begin
            wr(8'h51, {13'h0, i[2:0]});
            d = $random(seed);
            conv(3'b000, i == 4 ? 12'h000 : i == 5 ? 12'hfff : d[11:0]);
        end
        d = $random(seed);
        wr(8'h57, d);
        d = $random(seed);
        wr(8'h58, d);
        @(posedge clk);
        alu_diag_enable <= 1'b1;
        for (i = 0; i < 7; i++)
        begin
            d = $random(seed);
            conv(i[2:0], i == 5 ? mr[8'h57][11:0] : i == 3 ? mr[8'h58][11:0] : d[11:0]);
        end
        for (i = 0; i < 4; i++)
        begin
            d = $random(seed);
            @(posedge clk);
            diag_meas_valid <= 1'b1;
            diag_meas_data <= {d[15:4], d[1:0]};
            @(posedge clk);
            diag_meas_valid <= 1'b0;
            mr[8'h50] = {d[15:4], d[1:0], 2'b00};
            rd(8'h50);
        end
        tally_and_finish();
    end
endmodule
